// File: verilog/bsl_pkg.sv
package bsl_pkg;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned SETTLE_NS = 1000;
    localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] SETTLE_LAST = 6'(SETTLE_CYC - 1);

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_STRAP = 8'h08;
    localparam logic [7:0] OFS_ADV = 8'h0c;
    localparam int unsigned CTRL_PD_BIT = 0;
    localparam int unsigned CTRL_SRST_BIT = 1;
    localparam int unsigned CTRL_ANEN_BIT = 2;
    localparam int unsigned CTRL_TSEN_BIT = 3;
    localparam int unsigned STAT_PDRDY_BIT = 0;
    localparam int unsigned STAT_NEGOT_BIT = 1;
    localparam int unsigned STAT_LINK_BIT = 2;
    localparam int unsigned STAT_MASTER_BIT = 3;
    localparam int unsigned STAT_HILVL_BIT = 4;
    localparam int unsigned ADV_ROLE_BIT = 0;
    localparam int unsigned ADV_HIABLE_BIT = 1;
    localparam int unsigned ADV_HIREQ_BIT = 2;
    localparam logic CTRL_ANEN_RST = 1'b1;
    localparam logic CTRL_TSEN_RST = 1'b0;
    localparam logic ADV_HIREQ_RST = 1'b0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        PROTO_CHUNK_PROT = 2'h0,
        PROTO_CHUNK_PLAIN = 2'h1,
        PROTO_GEN_CRC = 2'h2,
        PROTO_GEN_PLAIN = 2'h3
    } bsl_proto_t;

    // remote role advertisement, bit 0 set means master side
    typedef enum logic [1:0] {
        LP_PREFER_SLAVE = 2'h0,
        LP_PREFER_MASTER = 2'h1,
        LP_FORCE_SLAVE = 2'h2,
        LP_FORCE_MASTER = 2'h3
    } bsl_lp_role_t;

    typedef struct packed {
        logic host_protocol_strap_hi;
        logic host_protocol_strap_lo;
        logic amplitude_limit_strap;
        logic role_preference_strap;
        logic powerdown_after_reset_strap;
    } bsl_strap_t;

    typedef struct packed {
        logic valid;
        bsl_lp_role_t role;
        logic hi_able;
        logic hi_req;
    } bsl_partner_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } bsl_axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } bsl_axil_rsp_t;

endpackage

// File: verilog/bsl_sync3.sv
`timescale 1ns/1ps
// three-stage pin synchroniser; a level is accepted once stages two and three agree
module bsl_sync3 #(
    parameter int unsigned W = 5
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic [W-1:0] pin_in, // asynchronous pin levels
    output logic [W-1:0] level_out // filtered level
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] lvl;
    } bsl_sync_state_t;

    bsl_sync_state_t s_q;
    bsl_sync_state_t s_d;
    logic [W-1:0] lvl_d;

    // next state, per bit
    always_comb
    begin
        s_d = s_q;
        s_d.ff1 = pin_in;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        s_d.lvl = lvl_d;
    end

    // agreement filter; ff1 is seen only by ff2
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign lvl_d[i] = (s_q.ff2[i] == s_q.ff3[i]) ? s_q.ff3[i] : s_q.lvl[i];
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign level_out = s_q.lvl;
endmodule

// File: verilog/bsl_resolve.sv
`timescale 1ns/1ps
// role and transmit level outcome of negotiation
module bsl_resolve (
    input wire logic an_en, // negotiation enabled
    input wire logic role_pref, // 1 prefer master
    input wire logic hi_able, // local high level advertised
    input wire logic hi_req, // local high level requested
    input wire bsl_pkg::bsl_partner_t partner, // remote advertisement
    output logic role_master, // resolved role, 1 master
    output logic level_hi // resolved level, 1 high
);
    import bsl_pkg::*;

    // role: fixed by preference without negotiation, else opposite of remote side, except master when both sides prefer master
    always_comb
    begin
        if (!an_en)
            role_master = role_pref;
        else if (partner.role == LP_FORCE_MASTER || partner.role == LP_FORCE_SLAVE)
            role_master = ~partner.role[0];
        else if (!role_pref)
            role_master = ~partner.role[0];
        else
            role_master = 1'b1;
    end

    // level: both able and either side asking; without negotiation, local able and asking only
    always_comb
    begin
        if (!an_en)
            level_hi = hi_able & hi_req;
        else
            level_hi = hi_able & partner.hi_able & (hi_req | partner.hi_req);
    end
endmodule

// File: verilog/bsl_top.sv
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// strap latch with register access and link start control
module bsl_top (
    input wire logic aclk, // 20 MHz system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire bsl_pkg::bsl_axil_req_t axil_req, // register bus request side
    output bsl_pkg::bsl_axil_rsp_t axil_rsp, // register bus answer side
    input wire bsl_pkg::bsl_strap_t strap_pin_i, // strap pin levels
    input wire logic ts_src, // timestamp timer level, same clock
    output logic ts_pin_o, // timestamp timer drive on role pin
    output logic ts_pin_oe, // drive enable for role pin
    input wire bsl_pkg::bsl_partner_t partner, // remote advertisement from link
    output logic an_start, // one-cycle pulse: start negotiation
    output logic link_en, // link up attempt allowed
    output logic role_master, // 1 master, 0 slave
    output logic level_hi, // 1 high transmit level
    output bsl_pkg::bsl_proto_t proto_sel, // host protocol selection
    output logic soft_powerdown_ready, // in soft power-down
    output logic sample_done // straps latched, pins released
);
    import bsl_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef enum logic [3:0] {
        ST_SAMPLE = 4'h1,
        ST_PWRDN = 4'h2,
        ST_NEGOT = 4'h4,
        ST_LINK = 4'h8
    } bsl_fsm_t;

    typedef struct packed {
        bsl_fsm_t fsm;
        logic [5:0] cnt;
        bsl_strap_t strap;
        logic soft_powerdown_ctrl;
        logic an_en;
        logic ts_en;
        logic role_pref;
        logic hi_able;
        logic hi_req;
        logic aw_have;
        logic [7:0] awaddr;
        logic w_have;
        logic [31:0] wdata;
        logic wstrb0;
        bsl_axil_rsp_t rsp;
        logic role_master;
        logic level_hi;
        logic an_start;
        logic link_en;
        bsl_proto_t proto;
        logic pd_rdy;
        logic done;
        logic ts_o;
        logic ts_oe;
    } bsl_state_t;

    localparam bsl_state_t RESET_STATE = '{
        fsm: ST_SAMPLE,
        an_en: CTRL_ANEN_RST,
        ts_en: CTRL_TSEN_RST,
        hi_req: ADV_HIREQ_RST,
        rsp: '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0},
        proto: PROTO_CHUNK_PROT,
        default: '0
    };

    bsl_state_t s_q;
    bsl_state_t s_d;
    bsl_strap_t strap_lvl;
    logic res_master;
    logic res_hi;
    logic wr_fire;
    logic in_sample;

    // decode of mapped word offsets, shared by read and write
    function automatic logic is_mapped(input logic [7:0] addr);
        is_mapped = (addr == OFS_CTRL) || (addr == OFS_STATUS) ||
                    (addr == OFS_STRAP) || (addr == OFS_ADV);
    endfunction

    // read data for a mapped offset
    function automatic logic [31:0] read_word(input bsl_state_t st, input logic [7:0] addr);
        logic [31:0] w;
        w = 32'h0;
        unique case (addr)
            OFS_CTRL:
            begin
                w[CTRL_PD_BIT] = st.soft_powerdown_ctrl;
                w[CTRL_ANEN_BIT] = st.an_en;
                w[CTRL_TSEN_BIT] = st.ts_en;
            end
            OFS_STATUS:
            begin
                w[STAT_PDRDY_BIT] = st.pd_rdy;
                w[STAT_NEGOT_BIT] = (st.fsm == ST_NEGOT);
                w[STAT_LINK_BIT] = st.link_en;
                w[STAT_MASTER_BIT] = st.role_master;
                w[STAT_HILVL_BIT] = st.level_hi;
            end
            OFS_STRAP:
                w = {27'h0, st.strap};
            OFS_ADV:
            begin
                w[ADV_ROLE_BIT] = st.role_pref;
                w[ADV_HIABLE_BIT] = st.hi_able;
                w[ADV_HIREQ_BIT] = st.hi_req;
            end
            default:
                w = 32'h0;
        endcase
        return w;
    endfunction

    // ************************************************************
    // pin filter and negotiation outcome
    // ************************************************************
    bsl_sync3 #(
        .W(5)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(strap_pin_i),
        .level_out(strap_lvl)
    );

    bsl_resolve u_resolve (
        .an_en(s_q.an_en),
        .role_pref(s_q.role_pref),
        .hi_able(s_q.hi_able),
        .hi_req(s_q.hi_req),
        .partner(partner),
        .role_master(res_master),
        .level_hi(res_hi)
    );

    assign in_sample = (s_q.fsm == ST_SAMPLE);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        s_d = s_q;
        s_d.an_start = 1'b0;
        wr_fire = 1'b0;

        // write address and data taken independently
        if (axil_req.awvalid && s_q.rsp.awready)
        begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = axil_req.awaddr;
            s_d.rsp.awready = 1'b0;
        end
        if (axil_req.wvalid && s_q.rsp.wready)
        begin
            s_d.w_have = 1'b1;
            s_d.wdata = axil_req.wdata;
            s_d.wstrb0 = axil_req.wstrb[0];
            s_d.rsp.wready = 1'b0;
        end
        if (s_q.rsp.bvalid && axil_req.bready)
        begin
            s_d.rsp.bvalid = 1'b0;
            s_d.rsp.awready = 1'b1;
            s_d.rsp.wready = 1'b1;
        end
        if (s_d.aw_have && s_d.w_have && !s_q.rsp.bvalid)
        begin
            wr_fire = 1'b1;
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = is_mapped(s_d.awaddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // read channel, answered on the same edge that takes the address
        if (s_q.rsp.rvalid && axil_req.rready)
        begin
            s_d.rsp.rvalid = 1'b0;
            s_d.rsp.arready = 1'b1;
        end
        if (axil_req.arvalid && s_q.rsp.arready)
        begin
            s_d.rsp.arready = 1'b0;
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = read_word(s_q, axil_req.araddr);
            s_d.rsp.rresp = is_mapped(axil_req.araddr) ? RESP_OKAY : RESP_SLVERR;
        end

        // software overrides, accepted only once sampling is over
        if (wr_fire && s_d.wstrb0 && !in_sample)
        begin
            if (s_d.awaddr == OFS_CTRL)
            begin
                s_d.soft_powerdown_ctrl = s_d.wdata[CTRL_PD_BIT];
                s_d.an_en = s_d.wdata[CTRL_ANEN_BIT];
                s_d.ts_en = s_d.wdata[CTRL_TSEN_BIT];
            end
            if (s_d.awaddr == OFS_ADV)
            begin
                s_d.role_pref = s_d.wdata[ADV_ROLE_BIT];
                s_d.hi_able = s_d.wdata[ADV_HIABLE_BIT] & ~s_q.strap.amplitude_limit_strap;
                s_d.hi_req = s_d.wdata[ADV_HIREQ_BIT];
            end
        end

        // sequencing
        unique case (s_q.fsm)
            ST_SAMPLE:
            begin
                s_d.link_en = 1'b0;
                s_d.level_hi = 1'b0;
                s_d.cnt = s_q.cnt + 6'h1;
                if (s_q.cnt == SETTLE_LAST)
                begin
                    // latch once; open pins read low through the pull-downs
                    s_d.strap = strap_lvl;
                    s_d.soft_powerdown_ctrl = ~strap_lvl.powerdown_after_reset_strap;
                    s_d.role_pref = strap_lvl.role_preference_strap;
                    s_d.hi_able = ~strap_lvl.amplitude_limit_strap;
                    s_d.hi_req = ADV_HIREQ_RST;
                    s_d.an_en = CTRL_ANEN_RST;
                    s_d.proto = bsl_proto_t'({strap_lvl.host_protocol_strap_hi,
                                              strap_lvl.host_protocol_strap_lo});
                    s_d.cnt = 6'h0;
                    if (strap_lvl.powerdown_after_reset_strap)
                    begin
                        s_d.fsm = ST_NEGOT;
                        s_d.an_start = 1'b1;
                    end
                    else
                        s_d.fsm = ST_PWRDN;
                end
            end
            ST_PWRDN:
            begin
                s_d.link_en = 1'b0;
                if (!s_d.soft_powerdown_ctrl)
                begin
                    s_d.fsm = ST_NEGOT;
                    s_d.an_start = 1'b1;
                end
            end
            ST_NEGOT:
            begin
                if (s_d.soft_powerdown_ctrl)
                    s_d.fsm = ST_PWRDN;
                else if (!s_q.an_en || partner.valid)
                begin
                    s_d.fsm = ST_LINK;
                    s_d.role_master = res_master;
                    s_d.level_hi = res_hi;
                    s_d.link_en = 1'b1;
                end
            end
            ST_LINK:
            begin
                if (s_d.soft_powerdown_ctrl)
                begin
                    s_d.fsm = ST_PWRDN;
                    s_d.link_en = 1'b0;
                end
            end
            default:
            begin
                s_d.fsm = ST_SAMPLE;
                s_d.cnt = 6'h0;
            end
        endcase

        // software reset restarts sampling and wins over the sequencer
        if (wr_fire && s_d.wstrb0 && !in_sample && s_d.awaddr == OFS_CTRL &&
            s_d.wdata[CTRL_SRST_BIT])
        begin
            s_d.fsm = ST_SAMPLE;
            s_d.cnt = 6'h0;
            s_d.link_en = 1'b0;
            s_d.an_start = 1'b0;
        end

        // derived outputs; role pin left undriven while being sampled
        s_d.pd_rdy = (s_d.fsm == ST_PWRDN);
        s_d.done = (s_d.fsm != ST_SAMPLE);
        s_d.ts_oe = s_d.done && s_d.ts_en;
        s_d.ts_o = ts_src;
    end

    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= RESET_STATE;
        else
            s_q <= s_d;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign axil_rsp = s_q.rsp;
    assign ts_pin_o = s_q.ts_o;
    assign ts_pin_oe = s_q.ts_oe;
    assign an_start = s_q.an_start;
    assign link_en = s_q.link_en;
    assign role_master = s_q.role_master;
    assign level_hi = s_q.level_hi;
    assign proto_sel = s_q.proto;
    assign soft_powerdown_ready = s_q.pd_rdy;
    assign sample_done = s_q.done;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_pd_strap_low: assert property ($fell(in_sample) && !s_q.strap.powerdown_after_reset_strap
        |-> soft_powerdown_ready && !link_en)
        else $error("low power-down strap did not enter power-down");
    a_pd_strap_high: assert property ($fell(in_sample) && s_q.strap.powerdown_after_reset_strap
        |-> an_start && s_q.fsm == ST_NEGOT)
        else $error("high power-down strap did not start negotiation");
    a_role_default: assert property ($fell(in_sample)
        |-> s_q.role_pref == s_q.strap.role_preference_strap)
        else $error("role default differs from strap");
    a_amp_default: assert property ($fell(in_sample)
        |-> s_q.hi_able == !s_q.strap.amplitude_limit_strap)
        else $error("amplitude default differs from strap");
    a_amp_locked: assert property (!in_sample && s_q.strap.amplitude_limit_strap
        |-> !s_q.hi_able && !level_hi)
        else $error("high level allowed despite limit strap");
    a_strap_held: assert property (!in_sample && !$past(in_sample) |-> $stable(s_q.strap))
        else $error("latched straps changed outside sampling");
    a_proto_sel: assert property ($fell(in_sample) |-> proto_sel ==
        {s_q.strap.host_protocol_strap_hi, s_q.strap.host_protocol_strap_lo})
        else $error("protocol selection differs from straps");
    a_pd_ready: assert property (soft_powerdown_ready == (s_q.fsm == ST_PWRDN))
        else $error("power-down ready does not match state");
    a_pd_exit: assert property (s_q.fsm == ST_PWRDN ##1 s_q.fsm == ST_NEGOT
        |-> !s_q.soft_powerdown_ctrl && an_start)
        else $error("power-down left without control cleared");
    a_release_start: assert property ($fell(s_q.soft_powerdown_ctrl) && !in_sample
        |-> s_q.fsm == ST_NEGOT && an_start ##1 !an_start)
        else $error("clearing power-down did not start negotiation");
    a_pin_released: assert property (in_sample |-> !ts_pin_oe ##0 !sample_done)
        else $error("role pin driven during sampling");
    a_sample_len: assert property ($rose(in_sample) |-> in_sample [*8])
        else $error("sampling window too short");

    c_to_pwrdn: cover property (in_sample ##1 s_q.fsm == ST_PWRDN);
    c_to_negot: cover property (in_sample ##1 s_q.fsm == ST_NEGOT);
    c_link_up: cover property (s_q.fsm == ST_NEGOT ##1 s_q.fsm == ST_LINK);
    c_soft_reset: cover property (s_q.fsm == ST_LINK ##1 in_sample);
endmodule

// File: tb/bsl_strap_model.sv
`timescale 1ns/1ps
// ************************************************************
// strap pins as the device sees them
// ************************************************************
module bsl_strap_model
    import bsl_pkg::*;
(
    input wire bsl_pkg::bsl_strap_t drv_en, // host gpio drives the pin
    input wire bsl_pkg::bsl_strap_t drv_val, // level driven by host
    output bsl_pkg::bsl_strap_t pin // resolved pin level
);
    // an undriven pin falls to its internal pull-down
    assign pin = drv_en & drv_val;
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
// ************************************************************
// strap latch bench
// ************************************************************
module tb_top;
    import bsl_pkg::*;
    logic aclk;
    logic aresetn;
    bsl_axil_req_t req;
    bsl_axil_rsp_t rsp;
    bsl_strap_t en, val, pins;
    bsl_partner_t partner;
    logic an_start, link_en, role_master, level_hi, pd_rdy, sample_done;
    bsl_proto_t proto_sel;
    logic [31:0] rd;
    logic [1:0] resp;
    logic ts, ts_o, ts_oe;
    int fail_count = 0;
    int n_tests = 0;
    int an_cnt = 0;
    int an_base = 0;
    int cyc = 0;

    bsl_strap_model u_bsl_strap_model (.drv_en(en), .drv_val(val), .pin(pins));
    bsl_top u_bsl_top (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
        .strap_pin_i(pins), .ts_src(ts), .ts_pin_o(ts_o), .ts_pin_oe(ts_oe), .partner(partner),
        .an_start(an_start), .link_en(link_en), .role_master(role_master),
        .level_hi(level_hi), .proto_sel(proto_sel), .soft_powerdown_ready(pd_rdy),
        .sample_done(sample_done));

    // 50 ns clock
    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // counts negotiation starts and cuts a hang short
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (an_start === 1'b1)
            an_cnt <= an_cnt + 1;
        if (cyc == 2000)
        begin
            fail_count = fail_count + 1;
            give_verdict();
        end
    end

    task automatic give_verdict();
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one write, address and data offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (req.awvalid && rsp.awready)
                req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready)
                req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
        req.bready <= 1'b0;
        resp = rsp.bresp;
    endtask

    // one read, data taken at the handshake edge
    task automatic axr(input logic [7:0] a);
        @(posedge aclk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (req.arvalid && rsp.arready)
                req.arvalid <= 1'b0;
        end while (rsp.rvalid !== 1'b1);
        req.rready <= 1'b0;
        rd = rsp.rdata;
        resp = rsp.rresp;
    endtask

    // software or pin reset, then wait out the sampling window
    task automatic restart(input bit sw);
        an_base = an_cnt;
        if (sw)
            axw(OFS_CTRL, 32'h6);
        else
        begin
            @(posedge aclk);
            aresetn <= 1'b0;
            repeat (5) @(posedge aclk);
            aresetn <= 1'b1;
        end
        repeat (SETTLE_CYC + 4) @(posedge aclk);
    endtask

    // main sequence
    initial
    begin
        aresetn = 1'b0;
        req = '0;
        ts = 1'b0;
        en = '0;
        val = '0;
        partner = '{valid: 1'b1, role: LP_PREFER_MASTER, hi_able: 1'b1, hi_req: 1'b1};
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (SETTLE_CYC + 4) @(posedge aclk);
        axr(OFS_STRAP);
        chk(rd, 32'h0);
        chk({31'h0, pd_rdy}, 32'h1);
        chk({31'h0, link_en}, 32'h0);
        chk(an_cnt, 0);
        chk({30'h0, proto_sel}, {30'h0, PROTO_CHUNK_PROT});
        axr(OFS_ADV);
        chk(rd, 32'h2);
        axr(OFS_CTRL);
        chk(rd, 32'h5);
        axw(OFS_STATUS, 32'h0);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        axr(8'h10);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        chk(rd, 32'h0);
        axw(OFS_CTRL, 32'h4);
        repeat (3) @(posedge aclk);
        chk(an_cnt, 1);
        chk({31'h0, pd_rdy}, 32'h0);
        chk({31'h0, link_en}, 32'h1);
        chk({31'h0, role_master}, 32'h0);
        chk({31'h0, level_hi}, 32'h1);
        axw(OFS_CTRL, 32'h5);
        repeat (2) @(posedge aclk);
        chk({31'h0, pd_rdy}, 32'h1);
        chk({31'h0, link_en}, 32'h0);
        partner.role <= LP_FORCE_MASTER;
        axw(OFS_ADV, 32'h1);
        axw(OFS_CTRL, 32'h0);
        repeat (3) @(posedge aclk);
        chk({31'h0, role_master}, 32'h1);
        chk({31'h0, level_hi}, 32'h0);
        ts <= 1'b1;
        axw(OFS_CTRL, 32'h8);
        repeat (2) @(posedge aclk);
        chk({30'h0, ts_oe, ts_o}, 32'h3);
        axw(OFS_CTRL, 32'ha);
        chk({30'h0, ts_oe, sample_done}, 32'h0);
        repeat (SETTLE_CYC + 4) @(posedge aclk);
        chk({29'h0, ts_oe, sample_done, pd_rdy}, 32'h7);
        for (int i = 0; i < 4; i++)
        begin
            partner.role <= LP_PREFER_MASTER;
            en <= 5'h1f;
            val <= {i[1], i[0], i[0], i[1], 1'b1};
            restart(i[0]);
            chk({30'h0, proto_sel}, i);
            chk({31'h0, role_master}, {31'h0, i[1]});
            chk({31'h0, level_hi}, {31'h0, ~i[0]});
            chk({31'h0, link_en}, 32'h1);
            chk(an_cnt - an_base, 1);
            val <= ~val;
            axr(OFS_STRAP);
            chk(rd, {27'h0, i[1], i[0], i[0], i[1], 1'b1});
            axw(OFS_ADV, 32'h6);
            axr(OFS_ADV);
            chk(rd, i[0] ? 32'h4 : 32'h6);
        end
        give_verdict();
    end
endmodule
